// [rtl/ras_params.svh]
// Purpose: Constants for the two-wire register access slave
// Assumes: Included by the package and by the slave module
// Notes:   Device addresses are 7-bit; register addresses are RAS_AW (8) bits
`ifndef RAS_PARAMS_SVH
`define RAS_PARAMS_SVH

// ----------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------
`define RAS_FIXED_HI     5'h0a
`define RAS_SAM_ADDR_DEF 7'h2c
`define RAS_FIFO_ADDR    8'h05
`define RAS_AW           8

// ----------------------------------------------------------------
// Link timing
// ----------------------------------------------------------------
`define RAS_CLK_KHZ      100000
`define RAS_SCL_MAX_KHZ  5000
`define RAS_SCL_MIN_CYC  (`RAS_CLK_KHZ / `RAS_SCL_MAX_KHZ)

`endif

// [rtl/ras_pkg.sv]
// Purpose: Types for the two-wire register access slave
// Assumes: ras_params.svh on the include path
// Notes:   Register side write request travels as one struct
package ras_pkg;
  `include "ras_params.svh"

  typedef enum logic [2:0] {
    sIdle, sDevAddr, sRegAddr, sWrData, sByteEnd, sAck, sRead, sMack
  } ras_state_e;

  typedef struct packed {
    logic                 valid;
    logic [`RAS_AW-1:0]   addr;
    logic [7:0]           data;
  } ras_regwr_s;
endpackage : ras_pkg

// [rtl/ras_sync.sv]
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs idle high
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module ras_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] din,
  output      logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta <= '1;
      dout <= '1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : ras_sync

// [rtl/ras_slave.sv]
// Purpose: Two-wire slave giving register write and read access
// Assumes: SCL below 5 MHz, far slower than mclk; point to point link
// Notes:   SDA is let go a little into SCL high; the keeper bridges that gap
// Contract
// - First byte is register address, rest data
// - FIFO address: all data bytes, address held
// - Read direction returns pointed register contents
// - Pointer advances after each returned byte
// - Pointer never advances at FIFO address
// - Never stretch SCL, follow master timing
// - Same framing and acknowledge as fast mode
// - Address upper five bits fixed 01010
// - Pin option: bit one zero, bit zero pin
// - SDA driven only while SCL low
// - Each side owns its SDA enable
// - Keeper holds last SDA level
// - One master, one slave only
// - Secure port address from configuration, default 0101100
// - MSB first, receiver acknowledges low
// - Master NAK ends read, device releases
`timescale 1ns/100ps
`include "ras_params.svh"
module ras_slave #(
  parameter logic [`RAS_AW-1:0] FIFO_ADDR = `RAS_FIFO_ADDR
) (
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic                scl,
  input  wire logic                sdaIn,
  output      logic                sdaOut,
  output      logic                sdaOe,
  output      logic                sdaKeep,
  input  wire logic                addrPin,
  input  wire logic                addrFromPin,
  input  wire logic [1:0]          cfgAddrLow,
  input  wire logic                samMode,
  input  wire logic [6:0]          cfgSamAddr,
  output      ras_pkg::ras_regwr_s regWr,
  output      logic [`RAS_AW-1:0]  regPtr,
  output      logic                regRdStrobe,
  input  wire logic [7:0]          regRdData,
  output      logic                busy
);
  import ras_pkg::*;

  // ----------------------------------------------------------------
  // Pin sampling and line events
  // ----------------------------------------------------------------
  logic [2:0]   syncOut;
  logic         sclS;
  logic         sdaS;
  logic         addrPinS;
  logic         sclD;
  logic         sdaD;
  logic         sclRise;
  logic         sclFall;
  logic         startCond;
  logic         stopCond;
  ras_state_e   state;
  ras_state_e   rxKind;
  ras_state_e   ackNext;
  logic [2:0]   bitCnt;
  logic [7:0]   rxShift;
  logic [7:0]   txShift;
  logic [6:0]   devAddr;

  // SCL is only sampled; there is no SCL driver at all
  ras_sync #(
    .WIDTH (3)
  ) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .din     ({scl, sdaIn, addrPin}),
    .dout    (syncOut)
  );

  assign sclS     = syncOut[2];
  assign sdaS     = syncOut[1];
  assign addrPinS = syncOut[0];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
    end else begin
      sclD <= sclS;
      sdaD <= sdaS;
    end
  end

  // Start and stop are SDA edges while SCL stays high
  assign sclRise   = sclS & ~sclD;
  assign sclFall   = ~sclS & sclD;
  assign startCond = sclS & sclD & sdaD & ~sdaS;
  assign stopCond  = sclS & sclD & ~sdaD & sdaS;

  // ----------------------------------------------------------------
  // Device address selection
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      devAddr <= `RAS_SAM_ADDR_DEF;
    end else if (samMode) begin
      devAddr <= cfgSamAddr;
    end else if (addrFromPin) begin
      devAddr <= {`RAS_FIXED_HI, 1'b0, addrPinS};
    end else begin
      devAddr <= {`RAS_FIXED_HI, cfgAddrLow};
    end
  end

  // Pointer holds at the FIFO so a burst drains or fills it
  function automatic logic [`RAS_AW-1:0] nextPtr(input logic [`RAS_AW-1:0] p);
    nextPtr = (p == FIFO_ADDR) ? p : p + 8'd1;
  endfunction : nextPtr

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    regWr.valid <= 1'b0;
    regRdStrobe <= 1'b0;
    if (sys_rst) begin
      state      <= sIdle;
      rxKind     <= sIdle;
      ackNext    <= sIdle;
      bitCnt     <= 3'h0;
      rxShift    <= 8'h00;
      txShift    <= 8'h00;
      sdaOut     <= 1'b1;
      sdaOe      <= 1'b0;
      regPtr     <= 8'h00;
      regWr.addr <= 8'h00;
      regWr.data <= 8'h00;
    end else if (startCond) begin
      state  <= sDevAddr;
      bitCnt <= 3'h0;
      sdaOe  <= 1'b0;
    end else if (stopCond) begin
      state <= sIdle;
      sdaOe <= 1'b0;
    end else begin
      // Release on the cycle after the seen SCL rise, up to the fall; the keeper holds the level
      if (sclRise) begin
        sdaOe <= 1'b0;
      end
      case (state)
        sDevAddr, sRegAddr, sWrData: begin
          if (sclRise) begin
            rxShift <= {rxShift[6:0], sdaS};
            bitCnt  <= bitCnt + 3'h1;
            if (bitCnt == 3'h7) begin
              rxKind <= state;
              state  <= sByteEnd;
            end
          end
        end
        sByteEnd: begin
          if (sclFall) begin
            state  <= sAck;
            sdaOut <= 1'b0;
            sdaOe  <= 1'b1;
            if (rxKind == sDevAddr) begin
              if (rxShift[7:1] == devAddr) begin
                ackNext <= rxShift[0] ? sRead : sRegAddr;
              end else begin
                sdaOe <= 1'b0;
                state <= sIdle;
              end
            end else if (rxKind == sRegAddr) begin
              regPtr  <= rxShift;
              ackNext <= sWrData;
            end else begin
              regWr.valid <= 1'b1;
              regWr.addr  <= regPtr;
              regWr.data  <= rxShift;
              regPtr      <= nextPtr(regPtr);
              ackNext     <= sWrData;
            end
          end
        end
        sAck: begin
          if (sclFall) begin
            bitCnt <= 3'h0;
            if (ackNext == sRead) begin
              txShift     <= regRdData;
              regRdStrobe <= 1'b1;
              regPtr      <= nextPtr(regPtr);
              sdaOut      <= regRdData[7];
              sdaOe       <= 1'b1;
              state       <= sRead;
            end else begin
              state <= ackNext;
            end
          end
        end
        sRead: begin
          if (sclRise) begin
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == 3'h7) begin
              state <= sMack;
            end
          end else if (sclFall) begin
            txShift <= {txShift[6:0], 1'b0};
            sdaOut  <= txShift[6];
            sdaOe   <= 1'b1;
          end
        end
        sMack: begin
          if (sclRise) begin
            if (!sdaS) begin
              ackNext <= sRead;
              state   <= sAck;
            end else begin
              state <= sIdle;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus keeper and status
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sdaKeep <= 1'b1;
      busy    <= 1'b0;
    end else begin
      sdaKeep <= sdaOe ? sdaOut : sdaS;
      busy    <= (state != sIdle);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence addrMatchEnd;
    state == sByteEnd && sclFall && !startCond && !stopCond
      && rxKind == sDevAddr && rxShift[7:1] == devAddr;
  endsequence

  sequence ackDriven;
    sdaOe && !sdaOut && state == sAck;
  endsequence

  highRelease_a: assert property (sclRise |=> !sdaOe)
    else $error("SDA still driven after SCL rise");
  driveLow_a: assert property ($rose(sdaOe) |-> !sclS)
    else $error("SDA drive began while SCL high");
  addrAck_a: assert property (addrMatchEnd |=> ackDriven)
    else $error("Matching address not acknowledged low");
  wrFifo_a: assert property (regWr.valid && regWr.addr == FIFO_ADDR
      |-> regPtr == FIFO_ADDR)
    else $error("Pointer moved on FIFO write");
  wrInc_a: assert property (regWr.valid && regWr.addr != FIFO_ADDR
      |-> regPtr == regWr.addr + 8'd1)
    else $error("Pointer not advanced on register write");
  rdInc_a: assert property (regRdStrobe && $past(regPtr) != FIFO_ADDR
      |-> regPtr == $past(regPtr) + 8'd1)
    else $error("Read pointer did not advance by one");
  rdFifo_a: assert property (regRdStrobe && $past(regPtr) == FIFO_ADDR
      |-> regPtr == FIFO_ADDR)
    else $error("Read pointer left FIFO address");
  fixedHi_a: assert property (!samMode |=> devAddr[6:2] == `RAS_FIXED_HI)
    else $error("Upper address bits wrong");
  pinBit_a: assert property (!samMode && addrFromPin |=> devAddr[1] == 1'b0)
    else $error("Pin option address bit one not zero");
  nakRelease_a: assert property (state == sMack && sclRise && sdaS && !stopCond
      |=> (state == sIdle && !sdaOe) [*2])
    else $error("Device kept SDA after master NAK");
endmodule : ras_slave

// [sim/ras_host_model.sv]
// Purpose: Master at the far end of the point to point link
// Assumes: mclk 100 MHz; one SCL period is 16 mclk (160 ns)
// Notes:   Owns SCL and its own SDA enable; resolves the wire level
`timescale 1ns/100ps
module ras_host_model (
  input  wire logic       mclk,
  input  wire logic       sdaOut,
  input  wire logic       sdaOe,
  input  wire logic       sdaKeep,
  output      logic       scl,
  output      logic       sda,
  output      logic       resValid,
  output      logic [1:0] resKind,
  output      logic [7:0] resData
);
  logic mOe;
  logic mOut;
  // No pull-up: an undriven wire shows the keeper level
  assign sda = mOe ? mOut : (sdaOe ? sdaOut : sdaKeep);
  initial begin
    scl = 1'b1;
    mOe = 1'b1;
    mOut = 1'b1;
    resValid = 1'b0;
    resKind = 2'd0;
    resData = 8'h00;
  end
  // --------------------------------------------------------------
  // Bus cycles
  // --------------------------------------------------------------
  task automatic fall();
    scl <= 1'b0;
    mOe <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : fall
  task automatic cyc(input logic oe, input logic b, output logic r);
    @(posedge mclk);
    mOe <= oe;
    mOut <= b;
    repeat (4) @(posedge mclk);
    scl <= 1'b1;
    mOe <= 1'b0;
    repeat (4) @(posedge mclk);
    r = sda;
    repeat (4) @(posedge mclk);
    fall();
  endtask : cyc
  // Start when v is 1, stop when v is 0
  task automatic cond(input logic v);
    @(posedge mclk);
    mOe <= 1'b1;
    mOut <= v;
    repeat (4) @(posedge mclk);
    scl <= 1'b1;
    repeat (8) @(posedge mclk);
    mOut <= ~v;
    repeat (8) @(posedge mclk);
    if (v) fall();
  endtask : cond
  task automatic post(input logic [1:0] k, input logic [7:0] d);
    resKind <= k;
    resData <= d;
    resValid <= 1'b1;
    @(posedge mclk);
    resValid <= 1'b0;
  endtask : post
  task automatic sendByte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) cyc(1'b1, b[i], r);
    cyc(1'b0, 1'b1, r);
    post(2'd1, {7'h00, r});
  endtask : sendByte
  task automatic recvByte(input logic nak);
    logic [7:0] d;
    logic       r;
    for (int i = 7; i >= 0; i--) cyc(1'b0, 1'b1, d[i]);
    cyc(1'b1, nak, r);
    post(2'd2, d);
  endtask : recvByte
endmodule : ras_host_model

// [sim/ras_slave_tb_top.sv]
// Purpose: Self-checking bench for the register access slave
// Assumes: Host model drives the link; register file modelled here
// Notes:   Driver queues notes, monitor takes them as results appear
`timescale 1ns/100ps
`include "ras_params.svh"
module ras_slave_tb_top;
  import ras_pkg::*;
  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] addr;
    logic [7:0] data;
  } ras_note_s;
  logic       mclk = 1'b0;
  logic       sysRst = 1'b1;
  logic       addrPin = 1'b1;
  logic       addrFromPin = 1'b0;
  logic [1:0] cfgAddrLow = 2'b11;
  logic       samMode = 1'b0;
  logic [6:0] cfgSamAddr = `RAS_SAM_ADDR_DEF;
  logic [7:0] rnd;
  logic [6:0] devA;
  logic [6:0] devB;
  logic [7:0] fifoVal = 8'h40;
  logic [7:0] lfsrState = 8'd41;
  logic       scl, sda, sdaOut, sdaOe, sdaKeep, regRdStrobe, busy, resValid;
  logic [1:0] resKind;
  logic [7:0] resData, regPtr, regRdData;
  ras_regwr_s regWr;
  ras_note_s  expQ[$];
  ras_note_s  got, exp;
  int         fail_count = 0;
  int         samples_checked = 0;
  initial forever #5 mclk = ~mclk;
  assign regRdData = (regPtr === `RAS_FIFO_ADDR) ? fifoVal : (regPtr ^ 8'ha5);
  always @(posedge mclk) if (regRdStrobe === 1'b1) fifoVal <= fifoVal + 8'h01;
  ras_slave ras_slave_i (.mclk(mclk), .sys_rst(sysRst), .scl(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .sdaKeep(sdaKeep), .addrPin(addrPin),
    .addrFromPin(addrFromPin), .cfgAddrLow(cfgAddrLow), .samMode(samMode),
    .cfgSamAddr(cfgSamAddr), .regWr(regWr), .regPtr(regPtr),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData), .busy(busy));
  ras_host_model host_i (.mclk(mclk), .sdaOut(sdaOut), .sdaOe(sdaOe), .sdaKeep(sdaKeep),
    .scl(scl), .sda(sda), .resValid(resValid), .resKind(resKind), .resData(resData));
  // --------------------------------------------------------------
  // Checking
  // --------------------------------------------------------------
  always @(posedge mclk) begin
    if (regWr.valid === 1'b1 || resValid === 1'b1) begin
      got = (regWr.valid === 1'b1) ? {2'd0, regWr.addr, regWr.data} : {resKind, 8'h00, resData};
      exp = (expQ.size() > 0) ? expQ.pop_front() : '1;
      samples_checked++;
      if (got !== exp) begin
        fail_count++;
        $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
      if (regWr.valid === 1'b1 && busy !== 1'b1) begin
        fail_count++;
        $display("MISMATCH %0t busy low inside a frame", $time);
      end
    end
  end
  function automatic logic [7:0] lfsr();
    lfsrState = {lfsrState[6:0], lfsrState[7] ^ lfsrState[5] ^ lfsrState[4] ^ lfsrState[3]};
    return lfsrState;
  endfunction : lfsr
  task automatic tx(input logic [7:0] b, input logic nak);
    expQ.push_back({2'd1, 8'h00, 7'h00, nak});
    host_i.sendByte(b);
  endtask : tx
  task automatic wrFrame(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] n);
    logic [7:0] p;
    logic [7:0] d;
    p = ra;
    host_i.cond(1'b1);
    tx({dev, 1'b0}, 1'b0);
    tx(ra, 1'b0);
    for (logic [7:0] k = 8'd0; k < n; k++) begin
      d = lfsr();
      expQ.push_back({2'd0, p, d});
      tx(d, 1'b0);
      if (p != `RAS_FIFO_ADDR) p++;
    end
  endtask : wrFrame
  task automatic rdFrame(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] n);
    logic [7:0] p;
    logic [7:0] f;
    p = ra;
    f = fifoVal;
    wrFrame(dev, ra, 8'd0);
    host_i.cond(1'b1);
    tx({dev, 1'b1}, 1'b0);
    for (logic [7:0] k = 8'd0; k < n; k++) begin
      expQ.push_back({2'd2, 8'h00, ((p == `RAS_FIFO_ADDR) ? f + k : p ^ 8'ha5)});
      host_i.recvByte(k == n - 8'd1);
      if (p != `RAS_FIFO_ADDR) p++;
    end
    host_i.cond(1'b0);
  endtask : rdFrame
  task automatic badAddr(input logic [6:0] dev);
    host_i.cond(1'b1);
    // Read direction: its last bit is 1, so the kept level reads as no acknowledge
    tx({dev, 1'b1}, 1'b1);
    host_i.cond(1'b0);
  endtask : badAddr
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  initial begin
    repeat (40000) @(posedge mclk);
    fail_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    results();
  end
  initial begin
    repeat (20) @(posedge mclk);
    rnd = lfsr();
    sysRst <= 1'b0;
    cfgAddrLow <= rnd[1:0];
    addrPin <= rnd[2];
    repeat (8) @(posedge mclk);
    devA = {`RAS_FIXED_HI, rnd[1:0]};
    devB = {`RAS_FIXED_HI, 1'b0, rnd[2]};
    wrFrame(devA, lfsr() | 8'h80, 8'd3);
    host_i.cond(1'b0);
    wrFrame(devA, `RAS_FIFO_ADDR, 8'd3);
    host_i.cond(1'b0);
    $display("test write done");
    rdFrame(devA, lfsr() | 8'h80, 8'd3);
    rdFrame(devA, `RAS_FIFO_ADDR, 8'd3);
    $display("test read done");
    addrFromPin <= 1'b1;
    badAddr({`RAS_FIXED_HI, 1'b1, rnd[2]});
    wrFrame(devB, 8'h10, 8'd1);
    host_i.cond(1'b0);
    rnd = lfsr();
    devA = `RAS_SAM_ADDR_DEF ^ {rnd[7:6], 5'h00};
    cfgSamAddr <= devA;
    samMode <= 1'b1;
    badAddr(devB);
    rdFrame(devA, 8'h10, 8'd2);
    $display("test address done");
    repeat (20) @(posedge mclk);
    samples_checked++;
    if (busy !== 1'b0) begin
      fail_count++;
      $display("MISMATCH %0t busy high after stop", $time);
    end
    if (expQ.size() != 0) begin
      fail_count++;
      $display("MISMATCH %0t %0d results missing", $time, expQ.size());
    end
    results();
  end
endmodule : ras_slave_tb_top
